// ### inc/oia_pkg.sv
// Purpose: shared constants and types of the operand index adder
// Assumes: one 200 MHz clock, active-low asynchronous reset
// Notes: device numbers travel as plain binary integers of their value
package oia_pkg;
  localparam int OIA_WORD_W = 16;
  localparam int OIA_NUM_W = 3;
  localparam int OIA_NWORD = 8;
  localparam int OIA_WIDE_W = 32;
  localparam logic [15:0] OIA_WORD_RST = 16'h0000;
  localparam logic [2:0] OIA_DEFAULT_NUM = 3'h0;
  localparam int OIA_LATENCY = 2;
  localparam logic [31:0] OIA_DEC_DEV_MAX = 32'h0000_7FFF;
  localparam logic [31:0] OIA_OCT_DEV_MAX = 32'h0000_01FF;

  typedef enum logic [2:0] {
    OIA_OP_IDLE = 3'h0,
    OIA_OP_FETCH = 3'h1,
    OIA_OP_RD_WORD = 3'h3,
    OIA_OP_WR_WORD = 3'h2,
    OIA_OP_RD_PAIR = 3'h6,
    OIA_OP_WR_PAIR = 3'h7
  } oia_op_t;

  typedef enum logic [1:0] {
    OIA_K_DEC_DEV = 2'h0,
    OIA_K_DEC_CONST = 2'h1,
    OIA_K_HEX_CONST = 2'h3,
    OIA_K_OCT_DEV = 2'h2
  } oia_kind_t;
endpackage

// ### inc/oia_mem_if.sv
// Purpose: carrier between the adder and its index word store
// Assumes: one clock domain
// Notes: read data come back one edge after the address
`timescale 1ns/1ps
`default_nettype none
interface oia_mem_if;
  logic we;
  logic wide;
  logic wsel_hi;
  logic [2:0] waddr;
  logic [31:0] wdata;
  logic [2:0] raddr;
  logic [31:0] rdata;
  modport store (input we, input wide, input wsel_hi, input waddr, input wdata,
    input raddr, output rdata);
  modport user (output we, output wide, output wsel_hi, output waddr, output wdata,
    output raddr, input rdata);
endinterface
`default_nettype wire

// ### design/oia_store.sv
// Purpose: sixteen index words, eight high and eight low, 16 bits each
// Assumes: one write and one paired read per cycle
// Notes: cleared at reset; retention is fixed, nothing selects it
`timescale 1ns/1ps
`default_nettype none
module oia_store
  import oia_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  oia_mem_if.store mem
);
  typedef struct packed {
    logic [7:0][15:0] hi; // RL1
    logic [7:0][15:0] lo; // RL1
    logic [31:0] rd;
  } oia_store_st_t;

  oia_store_st_t st_r;
  oia_store_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (mem.we) begin
      if (mem.wide) begin
        // both halves change on the same edge
        st_nxt.hi[mem.waddr] = mem.wdata[31:16]; // RL8
        st_nxt.lo[mem.waddr] = mem.wdata[15:0]; // RL8
      end else if (mem.wsel_hi) begin
        st_nxt.hi[mem.waddr] = mem.wdata[15:0]; // RL2
      end else begin
        st_nxt.lo[mem.waddr] = mem.wdata[15:0]; // RL2
      end
    end
    // pair n read as one access, high word above low word
    st_nxt.rd = {st_r.hi[mem.raddr], st_r.lo[mem.raddr]}; // RL4 RL6
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0; // RL13
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem.rdata = st_r.rd;
endmodule
`default_nettype wire

// ### design/oia_top.sv
// Purpose: index register file with operand indexing adder
// Assumes: the sequencer issues at most one request per cycle
// Notes: every request answers exactly two edges after it is taken
// What this block does
// (RL1) sixteen 16-bit words: eight high, eight low
// (RL2) index words read and written like data
// (RL3) missing number selects word zero
// (RL4) low word n pairs with high word n
// (RL5) wide operand naming high word: no indexing
// (RL6) both halves read in one access
// (RL7) out-of-range wide indexed value raises error
// (RL8) pair write updates both halves together
// (RL9) decimal devices: base plus index, decimal
// (RL10) indexed decimal constant is constant plus index
// (RL11) octal devices: index added in octal
// (RL12) hex constant adds binary index value
// (RL13) retention fixed, not configurable
// (RL14) interrupt input not shared with counters
// (RL15) effective number formed within fetch cycle
`timescale 1ns/1ps
`default_nettype none
module oia_top
  import oia_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire oia_op_t req_op,
  input wire oia_kind_t req_kind,
  input wire logic req_sel_hi,
  input wire logic req_num_given,
  input wire logic [2:0] req_num,
  input wire logic [31:0] req_base,
  input wire logic req_wide,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_error
);
  typedef struct packed {
    logic p_valid;
    oia_op_t p_op;
    oia_kind_t p_kind;
    logic p_sel_hi;
    logic p_wide;
    logic [31:0] p_base;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic rsp_error;
  } oia_top_st_t;

  oia_top_st_t st_r;
  oia_top_st_t st_nxt;
  oia_mem_if mem ();

  logic [2:0] num_eff;
  logic [31:0] idx_val;
  logic [32:0] sum;
  logic err;

  oia_store u_store (
    .clk(clk),
    .resetn(resetn),
    .mem(mem)
  );

  // signed 32-bit overflow of a + b
  function automatic logic ovf32(input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] s);
    ovf32 = (a[31] == b[31]) && (s[31] != a[31]);
  endfunction

  // value outside the signed 16-bit range
  function automatic logic out16(input logic [31:0] v);
    out16 = (v[31:15] != 17'h00000) && (v[31:15] != 17'h1FFFF);
  endfunction

  // 16-bit index word widened with its sign
  function automatic logic [31:0] sext16(input logic [15:0] w);
    sext16 = {{16{w[15]}}, w};
  endfunction

  // word reads answer with the word in the low half
  function automatic logic [31:0] zext16(input logic [15:0] w);
    zext16 = {16'h0000, w};
  endfunction

  // highest device number of a device kind
  function automatic logic [31:0] dev_top(input oia_kind_t k);
    case (k)
      OIA_K_OCT_DEV: begin
        dev_top = OIA_OCT_DEV_MAX;
      end
      default: begin
        dev_top = OIA_DEC_DEV_MAX;
      end
    endcase
  endfunction

  // device number below zero or past the last device
  function automatic logic dev_out(input logic [32:0] s, input logic [31:0] top);
    dev_out = s[31] || (s[31:0] > top);
  endfunction

  assign num_eff = req_num_given ? req_num : OIA_DEFAULT_NUM; // RL3

  always_comb begin
    mem.we = 1'b0;
    mem.wide = 1'b0;
    mem.wsel_hi = req_sel_hi;
    mem.waddr = num_eff;
    mem.wdata = req_wdata;
    // a read taken with a write still sees the old pair
    mem.raddr = num_eff;
    case (req_op)
      OIA_OP_WR_WORD: begin
        mem.we = 1'b1; // RL2
      end
      OIA_OP_WR_PAIR: begin
        mem.we = 1'b1; // RL8
        mem.wide = 1'b1; // RL8
      end
      default: begin
        mem.we = 1'b0;
      end
    endcase
  end

  // index operand from the pair read one edge earlier
  always_comb begin
    if (st_r.p_wide) begin
      if (st_r.p_sel_hi) begin
        idx_val = 32'h0000_0000; // RL5
      end else begin
        idx_val = mem.rdata; // RL4 RL6
      end
    end else if (st_r.p_sel_hi) begin
      idx_val = sext16(mem.rdata[31:16]);
    end else begin
      idx_val = sext16(mem.rdata[15:0]);
    end
  end

  // device numbers are binary values; octal devices print the result in octal,
  // so an index of ten moves X0 to X12 with the same binary add
  assign sum = {1'b0, st_r.p_base} + {1'b0, idx_val}; // RL9 RL10 RL11 RL12 RL15

  always_comb begin
    err = 1'b0;
    case (st_r.p_kind)
      OIA_K_DEC_DEV: begin
        // a stale high half of a pair shows up here as a huge sum
        err = dev_out(sum, dev_top(st_r.p_kind)); // RL7 RL9
      end
      OIA_K_OCT_DEV: begin
        err = dev_out(sum, dev_top(st_r.p_kind)); // RL7 RL11
      end
      OIA_K_DEC_CONST: begin
        if (st_r.p_wide) begin
          err = ovf32(st_r.p_base, idx_val, sum[31:0]); // RL7 RL10
        end else begin
          err = out16(sum[31:0]); // RL10
        end
      end
      OIA_K_HEX_CONST: begin
        if (st_r.p_wide) begin
          // carry out is the only overflow of an unsigned add
          err = sum[32]; // RL7 RL12
        end else begin
          err = sum[31:16] != 16'h0000; // RL12
        end
      end
      default: begin
        err = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.p_valid = (req_op != OIA_OP_IDLE);
    st_nxt.p_op = req_op;
    st_nxt.p_kind = req_kind;
    st_nxt.p_sel_hi = req_sel_hi;
    st_nxt.p_wide = req_wide;
    st_nxt.p_base = req_base;
    st_nxt.rsp_valid = st_r.p_valid;
    st_nxt.rsp_error = 1'b0;
    st_nxt.rsp_data = 32'h0000_0000;
    case (st_r.p_op)
      OIA_OP_FETCH: begin
        st_nxt.rsp_data = sum[31:0]; // RL15
        st_nxt.rsp_error = err; // RL7
      end
      OIA_OP_RD_WORD: begin
        if (st_r.p_sel_hi) begin
          st_nxt.rsp_data = zext16(mem.rdata[31:16]); // RL2
        end else begin
          st_nxt.rsp_data = zext16(mem.rdata[15:0]); // RL2
        end
      end
      OIA_OP_RD_PAIR: begin
        st_nxt.rsp_data = mem.rdata; // RL6
      end
      default: begin
        st_nxt.rsp_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.rsp_valid;
  assign rsp_data = st_r.rsp_data;
  assign rsp_error = st_r.rsp_error;
endmodule
`default_nettype wire

// ### tb/oia_top_checker.sv
// Purpose: port checks of the index adder
// Assumes: one clock, resetn low active
// Notes: bound to oia_top
`timescale 1ns/1ps
`default_nettype none
module oia_top_checker
  import oia_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire oia_op_t req_op,
  input wire oia_kind_t req_kind,
  input wire logic req_sel_hi,
  input wire logic req_num_given,
  input wire logic [2:0] req_num,
  input wire logic [31:0] req_base,
  input wire logic req_wide,
  input wire logic [31:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wr;
    req_op == OIA_OP_WR_PAIR && req_num_given;
  endsequence
  sequence s_rd;
    req_op == OIA_OP_RD_PAIR && req_num_given && req_num == $past(req_num);
  endsequence
  property p_lat;
    req_op != OIA_OP_IDLE |-> ##2 rsp_valid;
  endproperty
  property p_idle;
    req_op == OIA_OP_IDLE |-> ##2 !rsp_valid;
  endproperty
  property p_err;
    rsp_error |-> rsp_valid && $past(req_op, 2) == OIA_OP_FETCH;
  endproperty
  property p_wr;
    req_op inside {OIA_OP_WR_WORD, OIA_OP_WR_PAIR} |-> ##2 rsp_data == 32'h0 && !rsp_error;
  endproperty
  property p_rdw;
    req_op == OIA_OP_RD_WORD |-> ##2 rsp_data[31:16] == 16'h0000 && !rsp_error;
  endproperty
  property p_pair;
    s_wr ##1 s_rd |-> ##2 rsp_data == $past(req_wdata, 3);
  endproperty
  // wide fetch on a high word adds nothing, so result is the base
  property p_hiwide;
    req_op == OIA_OP_FETCH && req_wide && req_sel_hi && req_kind == OIA_K_DEC_DEV &&
      req_base <= OIA_DEC_DEV_MAX |-> ##2 rsp_data == $past(req_base, 2) && !rsp_error;
  endproperty
  property p_oct;
    req_op == OIA_OP_FETCH && req_wide && req_sel_hi && req_kind == OIA_K_OCT_DEV &&
      req_base > OIA_OCT_DEV_MAX |-> ##2 rsp_error;
  endproperty
  a_lat: assert property (p_lat) else $error("no answer two edges on");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_err: assert property (p_err) else $error("error outside fetch");
  a_wr: assert property (p_wr) else $error("write answer not clean");
  a_rdw: assert property (p_rdw) else $error("word read not zero extended");
  a_pair: assert property (p_pair) else $error("pair read lost write");
  a_hiwide: assert property (p_hiwide) else $error("high word indexed");
  a_oct: assert property (p_oct) else $error("octal range not flagged");
endmodule
bind oia_top oia_top_checker u_chk (.clk, .resetn, .req_op, .req_kind, .req_sel_hi,
  .req_num_given, .req_num, .req_base, .req_wide, .req_wdata, .rsp_valid, .rsp_data,
  .rsp_error);
`default_nettype wire

// ### tb/oia_seq.sv
// Purpose: sequencer stand-in issuing requests
// Assumes: one request per edge
// Notes: idle scrambles data lines
`timescale 1ns/1ps
`default_nettype none
module oia_seq
  import oia_pkg::*;
(
  input wire logic clk,
  output var oia_op_t op,
  output var oia_kind_t kind,
  output logic hi,
  output logic given,
  output logic [2:0] num,
  output logic [31:0] base,
  output logic wide,
  output logic [31:0] wdata
);
  initial begin
    op = OIA_OP_IDLE;
    kind = OIA_K_DEC_DEV;
    {hi, given, num, base, wide, wdata} = '0;
  end
  // pair values always go as one wide write
  task automatic issue(input oia_op_t o, input oia_kind_t k, input logic h, g,
    input logic [2:0] n, input logic [31:0] b, input logic w, input logic [31:0] d);
    @(posedge clk);
    op <= o;
    kind <= k;
    {hi, given, num, base, wide, wdata} <= {h, g, n, b, w, d};
  endtask
  task automatic idle();
    @(posedge clk);
    op <= OIA_OP_IDLE;
    base <= ~base;
    wdata <= ~wdata;
  endtask
endmodule
`default_nettype wire

// ### tb/test_operand_index_adder.sv
// Purpose: random and corner tests of the index adder
// Assumes: answers come in request order
// Notes: words kept small so sums stay positive
`timescale 1ns/1ps
`default_nettype none
module test_operand_index_adder;
  import oia_pkg::*;
  logic clk = 0, resetn = 0, wide, hi, given, rsp_valid, rsp_error;
  oia_op_t op;
  oia_kind_t kind;
  logic [2:0] num;
  logic [31:0] base, wdata, rsp_data, r;
  logic [15:0] hw [8], lw [8];
  logic [33:0] q [$];
  int fails = 0, check_count = 0;
  initial forever #2.5 clk = ~clk;
  oia_seq u_oia_seq (.clk, .op, .kind, .hi, .given, .num, .base, .wide, .wdata);
  oia_top u_oia_top (.clk, .resetn, .req_op(op), .req_kind(kind), .req_sel_hi(hi),
    .req_num_given(given), .req_num(num), .req_base(base), .req_wide(wide),
    .req_wdata(wdata), .rsp_valid, .rsp_data, .rsp_error);
  task automatic check(input string nm, input logic [31:0] ex, se);
    check_count++;
    if (se !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, se);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input oia_op_t o, input logic h, input logic [2:0] n, input logic [31:0] d);
    if (o == OIA_OP_WR_PAIR) {hw[n], lw[n]} = d;
    else if (h) hw[n] = d[15:0];
    else lw[n] = d[15:0];
    q.push_back({2'b10, 32'h0});
    u_oia_seq.issue(o, OIA_K_DEC_DEV, h, 1'b1, n, 32'h0, 1'b0, d);
  endtask
  task automatic rd(input oia_op_t o, input logic h, input logic [2:0] n);
    q.push_back({2'b10, o == OIA_OP_RD_PAIR ? {hw[n], lw[n]} : {16'h0, h ? hw[n] : lw[n]}});
    u_oia_seq.issue(o, OIA_K_DEC_DEV, h, 1'b1, n, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic fetch(input oia_kind_t k, input logic h, g, input logic [2:0] n,
    input logic [31:0] b, input logic w);
    logic [2:0] m;
    logic [15:0] wd;
    logic [31:0] ix;
    longint s;
    logic e;
    m = g ? n : OIA_DEFAULT_NUM;
    wd = h ? hw[m] : lw[m];
    ix = w ? (h ? 32'h0 : {hw[m], lw[m]}) : {{16{wd[15]}}, wd};
    s = longint'(b) + longint'(ix);
    case (k)
      OIA_K_DEC_DEV: e = s > 32'h7FFF;
      OIA_K_OCT_DEV: e = s > 32'h1FF;
      OIA_K_DEC_CONST: e = w ? s > 32'h7FFFFFFF : s > 32'h7FFF;
      default: e = w ? s > 32'hFFFFFFFF : s > 32'hFFFF;
    endcase
    q.push_back({~e, e, s[31:0]});
    u_oia_seq.issue(OIA_OP_FETCH, k, h, g, n, b, w, 32'h0);
  endtask
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    if (q.size() == 0) check("rsp_valid", 32'h0, 32'h1);
    else begin
      check("rsp_error", {31'h0, q[0][32]}, {31'h0, rsp_error});
      if (q[0][33]) check("rsp_data", q[0][31:0], rsp_data);
      void'(q.pop_front());
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) {hw[i], lw[i]} = 32'h0;
    void'($urandom(32'h951996aa));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(OIA_OP_RD_PAIR, 1'b0, 3'(i));
    wr(OIA_OP_WR_PAIR, 1'b0, 3'h0, 32'd10);
    rd(OIA_OP_RD_PAIR, 1'b0, 3'h0);
    fetch(OIA_K_OCT_DEV, 1'b0, 1'b0, 3'h5, 32'h0, 1'b0);
    fetch(OIA_K_DEC_DEV, 1'b1, 1'b1, 3'h0, 32'h100, 1'b1);
    for (int i = 0; i < 300; i++) begin
      r = $urandom;
      case (r[9:8])
        2'h0: wr(OIA_OP_WR_PAIR, r[2], r[6:4], $urandom & 32'h0001_03FF);
        2'h1: wr(OIA_OP_WR_WORD, r[2], r[6:4], $urandom & 32'h3FF);
        2'h2: rd(r[3] ? OIA_OP_RD_PAIR : OIA_OP_RD_WORD, r[2], r[6:4]);
        default: fetch(oia_kind_t'(r[1:0]), r[2], r[3], r[6:4], $urandom & 32'h7FFF, r[7]);
      endcase
    end
    u_oia_seq.idle();
    for (int i = 0; i < 8 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0) check("answers left", 32'h0, 32'(q.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
